// [src/cbr_pkg.sv]
// Function
// - Vectors: soft FFFA/B, IRQ FFF8/9, NMI FFFC
// - Reset release loads PC from FFFE/FFFF
// - Float request floats address and read/write
// - Float request forces strobe and release low
// - After float, one dead sync cycle
// - Valid address strobe high on valid address
// - Stop request: finish instruction, raise release
// - Released: float buses, strobe low
// - NMI latched while halted, serviced later
// - Reset while halted: outputs idle, address FFFE
// - Late stop request halts after next instruction
// - One-cycle run request steps one instruction
// - Release low for stepped instruction's cycles
// - Flag register: mask bit 4, b6 b7 ones
// - Three 16-bit and three 8-bit registers
// - Stack pointer names next free location
// - Opcode byte alone fixes operation and mode
// - Reset sets interrupt mask
// - NMI edge, IRQ level and masked
package cbr_pkg;
    localparam logic [15:0] VEC_IRQ_HI = 16'hFFF8;
    localparam logic [15:0] VEC_SOFT_HI = 16'hFFFA;
    localparam logic [15:0] VEC_NMI_HI = 16'hFFFC;
    localparam logic [15:0] VEC_RST_HI = 16'hFFFE;
    localparam logic [15:0] VEC_LO_INC = 16'h0001;
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;
    localparam int FLG_I = 4;
    localparam int FLG_H = 5;
    localparam logic [7:0] FLG_ONES = 8'hC0;
    localparam logic [7:0] FLG_RESET = 8'hD0;
    localparam logic [7:0] OP_SOFT_INT = 8'h3F;
    // Idle pin levels: phase 1 high, run, both requests high
    localparam logic [6:0] PIN_IDLE = 7'h4E;
    localparam logic [7:0] OP_NOP = 8'h01;
    localparam logic [15:0] SP_RESET = 16'h0000;
    // Avalon register byte offsets
    localparam logic [4:0] REG_PC = 5'h00;
    localparam logic [4:0] REG_SP = 5'h04;
    localparam logic [4:0] REG_IDX = 5'h08;
    localparam logic [4:0] REG_ACC = 5'h0C;
    localparam logic [4:0] REG_FLG = 5'h10;
    localparam logic [4:0] REG_STAT = 5'h14;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [6:0] {
        ST_RESET = 7'h01,
        ST_VEC_HI = 7'h02,
        ST_VEC_LO = 7'h04,
        ST_FETCH = 7'h08,
        ST_OPER = 7'h10,
        ST_HALT = 7'h20,
        ST_SYNC = 7'h40
    } cbr_state_e;
    typedef struct packed {
        logic [15:0] addr;
        logic addr_oe;
        logic rw;
        logic rw_oe;
        logic strobe;
        logic released;
    } cbr_bus_s;
endpackage

// [src/cbr_core.sv]
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
module cbr_core
    import cbr_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic PHI1,
    input wire logic PHI2,
    input wire logic BUS_FLOAT_REQUEST,
    input wire logic RUN_N_STOP,
    input wire logic NMI_N,
    input wire logic IRQ_N,
    input wire logic [7:0] DATA_IN,
    input wire logic DATA_DRIVE_ENABLE,
    output logic [15:0] ADDR_OUT,
    output logic ADDR_OE,
    output logic RW_OUT,
    output logic RW_OE,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    output logic VALID_ADDRESS_STROBE,
    output logic BUS_RELEASED,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    logic [6:0] sync1_ff;
    logic [6:0] sync2_ff;
    logic p1, p2, flt, run, nmi_n, irq_n, drv_en;
    // Reset to idle levels so no false edge or float follows reset
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            sync1_ff <= PIN_IDLE;
            sync2_ff <= PIN_IDLE;
        end
        else
        begin
            sync1_ff <= {PHI1, PHI2, BUS_FLOAT_REQUEST, RUN_N_STOP, NMI_N, IRQ_N, DATA_DRIVE_ENABLE};
            sync2_ff <= sync1_ff;
        end
    end
    assign {p1, p2, flt, run, nmi_n, irq_n, drv_en} = sync2_ff;

    cbr_state_e state_ff, nxt_state;
    logic [15:0] pc_ff, nxt_pc, sp_ff, nxt_sp, idx_ff, nxt_idx, vec_ff, nxt_vec;
    logic [7:0] accumulator_a_ff, nxt_accumulator_a, accumulator_b_ff, nxt_accumulator_b, flg_ff, nxt_flg, op_ff, nxt_op;
    logic [1:0] left_ff, nxt_left;
    logic p1_d_ff, nxt_p1_d, p2_d_ff, nxt_p2_d, nmi_d_ff, nxt_nmi_d;
    logic nmi_pend_ff, nxt_nmi_pend, halt_req_ff, nxt_halt_req, flt_d_ff, nxt_flt_d;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ack_ff, nxt_ack;

    // Operand bytes after the opcode byte
    function automatic logic [1:0] op_len(input logic [7:0] op);
        logic [1:0] n;
        n = 2'd0;
        if (op[7] && (op[5:4] == 2'b00 || op[5:4] == 2'b10))
            n = (op[3:0] == 4'hC || op[3:0] == 4'hE) && op[5:4] == 2'b00 ? 2'd2 : 2'd1;
        else if (op[7] && op[5:4] == 2'b11)
            n = 2'd2;
        else if (op[7] && op[5:4] == 2'b01)
            n = 2'd1;
        else if (op[7:4] == 4'h2 || op[7:4] == 4'h6)
            n = 2'd1;
        else if (op[7:4] == 4'h7)
            n = 2'd2;
        return n;
    endfunction

    function automatic logic [31:0] rd_mux(input logic [4:0] a, input logic [15:0] pc, input logic [15:0] sp,
        input logic [15:0] idx, input logic [15:0] acc, input logic [7:0] flg, input logic [7:0] st);
        logic [31:0] r;
        r = UNMAPPED_DATA;
        case (a)
            REG_PC: r = {16'h0000, pc};
            REG_SP: r = {16'h0000, sp};
            REG_IDX: r = {16'h0000, idx};
            REG_ACC: r = {16'h0000, acc};
            REG_FLG: r = {24'h000000, flg | FLG_ONES};
            REG_STAT: r = {24'h000000, st};
            default: r = UNMAPPED_DATA;
        endcase
        return r;
    endfunction

    logic p1_fall, p2_rise, cyc_end, irq_take, stall;
    assign p1_fall = p1_d_ff && !p1;
    assign p2_rise = !p2_d_ff && p2;
    assign stall = flt;
    assign cyc_end = p2_rise && !stall;
    assign irq_take = !irq_n && !flg_ff[FLG_I];

    always_comb
    begin
        nxt_state = state_ff;
        nxt_pc = pc_ff;
        nxt_sp = sp_ff;
        nxt_idx = idx_ff;
        nxt_accumulator_a = accumulator_a_ff;
        nxt_accumulator_b = accumulator_b_ff;
        nxt_flg = flg_ff;
        nxt_vec = vec_ff;
        nxt_op = op_ff;
        nxt_left = left_ff;
        nxt_p1_d = p1;
        nxt_p2_d = p2;
        nxt_nmi_d = nmi_n;
        nxt_flt_d = flt;
        nxt_nmi_pend = nmi_pend_ff || (nmi_d_ff && !nmi_n);
        nxt_halt_req = halt_req_ff;
        if (p1_fall)
            nxt_halt_req = !run;
        nxt_rdata = rdata_ff;
        nxt_ack = 1'b0;
        if (SYS_RST)
        begin
            nxt_state = ST_RESET;
            nxt_flg = FLG_RESET;
            nxt_sp = SP_RESET;
            nxt_nmi_pend = 1'b0;
            nxt_halt_req = 1'b0;
        end
        else if (flt_d_ff && !flt)
            nxt_state = ST_SYNC;
        else if (cyc_end)
        begin
            case (state_ff)
                ST_RESET:
                begin
                    nxt_vec = VEC_RST_HI;
                    nxt_state = ST_VEC_HI;
                end
                ST_VEC_HI:
                begin
                    nxt_pc = {DATA_IN, 8'h00};
                    nxt_state = ST_VEC_LO;
                end
                ST_VEC_LO:
                begin
                    nxt_pc = {pc_ff[15:8], DATA_IN};
                    nxt_state = halt_req_ff ? ST_HALT : ST_FETCH;
                end
                ST_SYNC:
                    nxt_state = ST_FETCH;
                ST_HALT:
                    if (run)
                        nxt_state = ST_FETCH;
                ST_FETCH:
                begin
                    if (nmi_pend_ff || irq_take)
                    begin
                        nxt_vec = nmi_pend_ff ? VEC_NMI_HI : VEC_IRQ_HI;
                        nxt_nmi_pend = 1'b0;
                        nxt_flg[FLG_I] = 1'b1;
                        nxt_sp = sp_ff - 16'h0007;
                        nxt_state = ST_VEC_HI;
                    end
                    else
                    begin
                        nxt_op = DATA_IN;
                        nxt_pc = pc_ff + 16'h0001;
                        if (DATA_IN == OP_SOFT_INT)
                        begin
                            nxt_vec = VEC_SOFT_HI;
                            nxt_flg[FLG_I] = 1'b1;
                            nxt_sp = sp_ff - 16'h0007;
                            nxt_state = ST_VEC_HI;
                        end
                        else if (op_len(DATA_IN) != 2'd0)
                        begin
                            nxt_left = op_len(DATA_IN);
                            nxt_state = ST_OPER;
                        end
                        // Halt only once the fetched instruction is complete
                        else if (halt_req_ff)
                            nxt_state = ST_HALT;
                    end
                end
                ST_OPER:
                begin
                    nxt_pc = pc_ff + 16'h0001;
                    nxt_left = left_ff - 2'd1;
                    if (left_ff == 2'd1)
                        nxt_state = halt_req_ff ? ST_HALT : ST_FETCH;
                end
                default: nxt_state = ST_RESET;
            endcase
        end
        if (nmi_d_ff && !nmi_n && !SYS_RST)
            nxt_nmi_pend = 1'b1;
        // Read data registered with the acknowledge so it stands at acceptance
        if (avs_read && !ack_ff)
            nxt_rdata = rd_mux(avs_address, pc_ff, sp_ff, idx_ff, {accumulator_b_ff, accumulator_a_ff}, flg_ff,
                {1'b0, state_ff});
        if ((avs_read || avs_write) && !ack_ff)
            nxt_ack = 1'b1;
        if (avs_write && !avs_waitrequest && !SYS_RST)
        begin
            case (avs_address)
                REG_PC: nxt_pc = avs_writedata[15:0];
                REG_SP: nxt_sp = avs_writedata[15:0];
                REG_IDX: nxt_idx = avs_writedata[15:0];
                REG_ACC:
                begin
                    nxt_accumulator_a = avs_writedata[7:0];
                    nxt_accumulator_b = avs_writedata[15:8];
                end
                REG_FLG: nxt_flg = avs_writedata[7:0] | FLG_ONES;
                default: nxt_ack = nxt_ack;
            endcase
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            state_ff <= ST_RESET;
            pc_ff <= 16'h0000;
            idx_ff <= 16'h0000;
            accumulator_a_ff <= 8'h00;
            accumulator_b_ff <= 8'h00;
            vec_ff <= VEC_RST_HI;
            op_ff <= OP_NOP;
            left_ff <= 2'd0;
            p1_d_ff <= 1'b0;
            p2_d_ff <= 1'b0;
            nmi_d_ff <= 1'b1;
            flt_d_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            ack_ff <= 1'b0;
            sp_ff <= SP_RESET;
            flg_ff <= FLG_RESET;
            nmi_pend_ff <= 1'b0;
            halt_req_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            sp_ff <= nxt_sp;
            idx_ff <= nxt_idx;
            accumulator_a_ff <= nxt_accumulator_a;
            accumulator_b_ff <= nxt_accumulator_b;
            flg_ff <= nxt_flg;
            vec_ff <= nxt_vec;
            op_ff <= nxt_op;
            left_ff <= nxt_left;
            p1_d_ff <= nxt_p1_d;
            p2_d_ff <= nxt_p2_d;
            nmi_d_ff <= nxt_nmi_d;
            flt_d_ff <= nxt_flt_d;
            nmi_pend_ff <= nxt_nmi_pend;
            halt_req_ff <= nxt_halt_req;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
        end
    end

    // Pin drive is combinational from state so the float reacts within the sync delay
    cbr_bus_s bus;
    logic halted, accessing;
    assign halted = state_ff == ST_HALT;
    assign accessing = state_ff inside {ST_VEC_HI, ST_VEC_LO, ST_FETCH, ST_OPER};
    always_comb
    begin
        bus.addr = pc_ff;
        if (state_ff == ST_RESET)
            bus.addr = VEC_RST_HI;
        else if (state_ff == ST_VEC_HI)
            bus.addr = vec_ff;
        else if (state_ff == ST_VEC_LO)
            bus.addr = vec_ff + VEC_LO_INC;
        bus.addr_oe = !flt && !halted;
        bus.rw = 1'b1;
        bus.rw_oe = !flt && !halted;
        // The cycle in which the float ends is dead as well
        bus.strobe = accessing && !flt && !flt_d_ff && !SYS_RST;
        bus.released = halted && !flt && !SYS_RST;
    end
    assign ADDR_OUT = bus.addr;
    assign ADDR_OE = bus.addr_oe;
    assign RW_OUT = bus.rw;
    assign RW_OE = bus.rw_oe;
    assign VALID_ADDRESS_STROBE = bus.strobe;
    assign BUS_RELEASED = bus.released;
    assign DATA_OUT = accumulator_a_ff;
    assign DATA_OE = 1'b0 && drv_en && !halted;
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = !ack_ff;
endmodule

// [verif/cbr_core_asserts.sv]
`timescale 1ns/100ps
module cbr_core_asserts
    import cbr_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic BUS_FLOAT_REQUEST,
    input wire logic RUN_N_STOP,
    input wire logic [15:0] ADDR_OUT,
    input wire logic ADDR_OE,
    input wire logic RW_OUT,
    input wire logic RW_OE,
    input wire logic DATA_OE,
    input wire logic VALID_ADDRESS_STROBE,
    input wire logic BUS_RELEASED
);
    logic [7:0] stop_cnt_ff;
    logic [7:0] nxt_stop_cnt;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    // Limit covers a late stop plus an interrupt entry
    always_comb
    begin
        nxt_stop_cnt = stop_cnt_ff + 8'h01;
        if (RUN_N_STOP || BUS_FLOAT_REQUEST)
            nxt_stop_cnt = 8'h00;
        else if (stop_cnt_ff == 8'hF0)
            nxt_stop_cnt = stop_cnt_ff;
    end
    always_ff @(posedge CLOCK)
    begin
        stop_cnt_ff <= SYS_RST ? 8'h00 : nxt_stop_cnt;
    end
    sequence s_float_held;
        BUS_FLOAT_REQUEST [*4];
    endsequence
    sequence s_dead_sync;
        !VALID_ADDRESS_STROBE [*3];
    endsequence
    a_float_addr_off: assert property (s_float_held |-> !ADDR_OE && !RW_OE)
        else $error("address driven under float");
    a_float_strobe_low: assert property (s_float_held |-> !VALID_ADDRESS_STROBE && !BUS_RELEASED)
        else $error("strobe or release high under float");
    a_float_end_dead: assert property ($fell(BUS_FLOAT_REQUEST) |-> s_dead_sync)
        else $error("access right after float");
    a_strobe_addr_on: assert property (VALID_ADDRESS_STROBE |-> ADDR_OE && RW_OE)
        else $error("strobe without driven address");
    a_stop_halts: assert property (stop_cnt_ff == 8'hF0 |-> BUS_RELEASED)
        else $error("no halt after stop request");
    a_released_idle: assert property (BUS_RELEASED |-> !ADDR_OE && !RW_OE && !DATA_OE)
        else $error("bus driven while released");
    a_reset_outputs: assert property (disable iff (1'b0) SYS_RST ##1 SYS_RST |->
        ADDR_OUT == VEC_RST_HI && ADDR_OE && RW_OUT && !VALID_ADDRESS_STROBE && !BUS_RELEASED && !DATA_OE)
        else $error("wrong outputs in reset");
    a_step_low_span: assert property ($fell(BUS_RELEASED) |-> !BUS_RELEASED [*8])
        else $error("release low too short");
endmodule
bind cbr_core cbr_core_asserts u_chk
(
    .CLOCK, .SYS_RST, .BUS_FLOAT_REQUEST, .RUN_N_STOP, .ADDR_OUT, .ADDR_OE,
    .RW_OUT, .RW_OE, .DATA_OE, .VALID_ADDRESS_STROBE, .BUS_RELEASED
);

// [verif/cbr_master_model.sv]
`timescale 1ns/100ps
module cbr_master_model
    import cbr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic dma_req,
    input wire logic [15:0] addr,
    input wire logic strobe,
    output logic phi1,
    output logic phi2,
    output logic flt,
    output logic [7:0] din
);
    logic [2:0] ph_ff;
    logic hold;
    assign phi1 = ph_ff < 3'h3;
    assign phi2 = ph_ff[2] && ph_ff != 3'h7;
    // Float starts only with phi1 high, so the stall freezes a clean phase
    assign hold = dma_req && (flt || ph_ff == 3'h1);
    always_ff @(posedge clk)
    begin
        flt <= !rst && hold;
        ph_ff <= rst ? 3'h0 : (hold ? ph_ff : ph_ff + 3'h1);
        if (rst || !strobe)
            din <= rst ? 8'hA5 : ~din;
        else if (addr[15:4] != 12'hFFF)
            din <= (addr == 16'h1240) ? OP_SOFT_INT : OP_NOP;
        else
            din <= addr[0] ? 8'h34 : 8'h12;
    end
endmodule

// [verif/cbr_core_test.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
module cbr_core_test
    import cbr_pkg::*;
;
    logic CLOCK = 1'b0;
    logic SYS_RST = 1'b1;
    logic RUN_N_STOP = 1'b1;
    logic NMI_N = 1'b1;
    logic IRQ_N = 1'b1;
    logic dma = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic PHI1, PHI2, BUS_FLOAT_REQUEST, ADDR_OE, RW_OUT, RW_OE, DATA_OE;
    logic VALID_ADDRESS_STROBE, BUS_RELEASED, avs_waitrequest;
    logic [7:0] DATA_IN;
    logic [15:0] ADDR_OUT, last, pc;
    logic strobe_d = 1'b0;
    logic [31:0] avs_readdata, q, w;
    logic [15:0] q_addr[$];
    int num_errors = 0;
    int checks = 0;
    int hits[4] = '{0, 0, 0, 0};
    int base, spv;
    always #20 CLOCK = ~CLOCK;
    cbr_core DUT
    (
        .CLOCK, .SYS_RST, .PHI1, .PHI2, .BUS_FLOAT_REQUEST, .RUN_N_STOP, .NMI_N, .IRQ_N,
        .DATA_IN, .DATA_DRIVE_ENABLE(PHI2), .ADDR_OUT, .ADDR_OE, .RW_OUT, .RW_OE, .DATA_OUT(),
        .DATA_OE, .VALID_ADDRESS_STROBE, .BUS_RELEASED, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest
    );
    cbr_master_model u_master
    (
        .clk(CLOCK), .rst(SYS_RST), .dma_req(dma), .addr(ADDR_OUT), .strobe(VALID_ADDRESS_STROBE),
        .phi1(PHI1), .phi2(PHI2), .flt(BUS_FLOAT_REQUEST), .din(DATA_IN)
    );
    always @(posedge CLOCK)
    begin
        if (SYS_RST)
            q_addr.delete();
        else if (VALID_ADDRESS_STROBE === 1'b1 && (ADDR_OUT !== last || !strobe_d))
        begin
            q_addr.push_back(ADDR_OUT);
            if (ADDR_OUT[15:3] == 13'h1FFF && !ADDR_OUT[0])
                hits[ADDR_OUT[2:1]]++;
        end
        last <= SYS_RST ? 16'h0 : ADDR_OUT;
        strobe_d <= VALID_ADDRESS_STROBE === 1'b1;
    end
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do
            @(posedge CLOCK);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic wait_rel(input logic v);
        int n;
        n = 0;
        while (BUS_RELEASED !== v && n < 400)
        begin
            @(posedge CLOCK);
            n++;
        end
        `CHK(BUS_RELEASED, v)
    endtask
    task automatic boot(input int n);
        SYS_RST <= 1'b1;
        repeat (n) @(posedge CLOCK);
        if (n == 3)
            `CHK({ADDR_OUT, ADDR_OE, RW_OUT, VALID_ADDRESS_STROBE, BUS_RELEASED}, {VEC_RST_HI, 4'hC})
        SYS_RST <= 1'b0;
        RUN_N_STOP <= 1'b1;
        repeat (100) @(posedge CLOCK);
        `CHK(q_addr[0], VEC_RST_HI)
        `CHK(q_addr[1], VEC_RST_HI + VEC_LO_INC)
        `CHK(q_addr[2], 16'h1234)
    endtask
    task summarize;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        w = $urandom(5);
        boot(2);
        rd(REG_FLG, {24'h0, FLG_RESET});
        dma <= 1'b1;
        repeat (16) @(posedge CLOCK);
        `CHK({ADDR_OE, RW_OE, VALID_ADDRESS_STROBE, BUS_RELEASED}, 4'h0)
        bus(1'b0, REG_PC, 32'h0);
        w = q;
        repeat ($urandom % 40) @(posedge CLOCK);
        rd(REG_PC, w);
        dma <= 1'b0;
        repeat ($urandom % 16) @(posedge CLOCK);
        RUN_N_STOP <= 1'b0;
        wait_rel(1'b1);
        // SP, index and ACC sit at 04, 08, 0C
        for (int i = 1; i < 4; i++)
        begin
            w = $urandom & 32'hFFFF;
            bus(1'b1, 5'(4 * i), w);
            rd(5'(4 * i), w);
            if (i == 1)
                spv = w;
        end
        base = hits[0] + hits[1] + hits[2];
        bus(1'b1, REG_FLG, 32'h0);
        rd(REG_FLG, {24'h0, FLG_ONES});
        bus(1'b1, 5'h18, 32'hFFFF_FFFF);
        rd(5'h18, UNMAPPED_DATA);
        bus(1'b0, REG_PC, 32'h0);
        pc = q[15:0];
        @(posedge PHI1);
        @(posedge CLOCK);
        RUN_N_STOP <= 1'b1;
        repeat (8) @(posedge CLOCK);
        RUN_N_STOP <= 1'b0;
        wait_rel(1'b0);
        wait_rel(1'b1);
        rd(REG_PC, {16'h0, pc == 16'h1240 ? 16'h1234 : pc + 16'h1});
        NMI_N <= 1'b0;
        repeat (40) @(posedge CLOCK);
        NMI_N <= 1'b1;
        `CHK(hits[2], 0)
        RUN_N_STOP <= 1'b1;
        repeat (200) @(posedge CLOCK);
        `CHK(hits[2], 1)
        IRQ_N <= 1'b0;
        repeat (100) @(posedge CLOCK);
        `CHK(hits[0], 0)
        RUN_N_STOP <= 1'b0;
        wait_rel(1'b1);
        bus(1'b1, REG_FLG, 32'h0);
        RUN_N_STOP <= 1'b1;
        repeat (100) @(posedge CLOCK);
        `CHK(hits[0], 1)
        IRQ_N <= 1'b1;
        repeat (400) @(posedge CLOCK);
        `CHK(hits[1] > 0, 1'b1)
        RUN_N_STOP <= 1'b0;
        wait_rel(1'b1);
        rd(REG_SP, (spv - 7 * (hits[0] + hits[1] + hits[2] - base)) & 32'hFFFF);
        boot(3);
        summarize();
    end
    initial
    begin
        repeat (20000) @(posedge CLOCK);
        num_errors++;
        summarize();
    end
endmodule
